// file: verification/ext_pins_model.sv
// pin-side partner: external clock and clear sources of both channels
// assumes the timer samples these pins on the rising edge of clk
`timescale 1ns/1ps
module ext_pins_model (
	input wire logic clk,
	output logic [1:0] ext_clock,
	output logic [1:0] ext_reset
);
	initial begin
		ext_clock = 2'b00;
		ext_reset = 2'b00;
	end
	// hold sets the pace: 1 gives the fastest edge rate the pins allow
	task automatic pulse(input int ch, input int n, input int hold);
		repeat (n) begin
			ext_clock[ch] <= 1'b1;
			repeat (hold) @(posedge clk);
			ext_clock[ch] <= 1'b0;
			repeat (hold) @(posedge clk);
		end
		// settle time so the counter has taken the last edge
		repeat (2) @(posedge clk);
	endtask
	task automatic set_reset(input int ch, input logic v);
		ext_reset[ch] <= v;
		@(posedge clk);
	endtask
endmodule

// file: verification/test_dual_channel_8bit_timer.sv
// self-checking bench for the dual 8-bit timer over AXI4-Lite
// assumes ext_pins_model drives the clock and clear pins
`timescale 1ns/1ps
module test_dual_channel_8bit_timer;
	import dual_timer_pkg::*;
	logic MCLK = 0;
	logic RST = 1;
	logic [AXI_ADDR_W-1:0] AWADDR = 0, ARADDR = 0;
	logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic [31:0] WDATA = 0;
	logic [3:0] WSTRB = 0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, ADC_TRIGGER;
	logic [1:0] BRESP, RRESP, EXT_CLOCK_PIN, EXT_RESET_PIN;
	logic [1:0] TIMER_OUT_PIN, MATCH_A_IRQ, MATCH_B_IRQ, WRAP_IRQ;
	logic [31:0] RDATA;
	logic [31:0] seed = 32'h2E9E;
	logic [33:0] rq[$], tq[$], seen, want, tol;
	logic [1:0] bq[$];
	logic adc_seen = 0;
	int divs[4] = '{8, 2, 64, 32};
	int bad_count = 0;
	int comparisons = 0;
	always #5 MCLK = ~MCLK;
	dual_channel_8bit_timer dut (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .EXT_CLOCK_PIN(EXT_CLOCK_PIN),
		.EXT_RESET_PIN(EXT_RESET_PIN), .TIMER_OUT_PIN(TIMER_OUT_PIN),
		.MATCH_A_IRQ(MATCH_A_IRQ), .MATCH_B_IRQ(MATCH_B_IRQ),
		.WRAP_IRQ(WRAP_IRQ), .ADC_TRIGGER(ADC_TRIGGER));
	ext_pins_model pins (.clk(MCLK), .ext_clock(EXT_CLOCK_PIN),
		.ext_reset(EXT_RESET_PIN));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [33:0] s, input logic [33:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d, compares %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic give_up();
		bad_count++;
		stop_test();
	endtask
	task automatic axw(input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s, input logic [1:0] r = RESP_OKAY);
		bit aw, w;
		int n;
		aw = 0;
		w = 0;
		n = 0;
		// an edge between transfers: no ready is dropped and raised at once
		@(posedge MCLK);
		bq.push_back(r);
		AWADDR <= a;
		WDATA <= {16'h0000, d};
		WSTRB <= s;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		// address and data may be taken at different edges
		while (!(aw && w)) begin
			@(posedge MCLK);
			if (!aw && AWREADY) begin
				aw = 1;
				AWVALID <= 1'b0;
			end
			if (!w && WREADY) begin
				w = 1;
				WVALID <= 1'b0;
			end
			n++;
			if (n > 50) give_up();
		end
		do begin
			@(posedge MCLK);
			n++;
			if (n > 100) give_up();
		end while (!BVALID);
		BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e,
		input logic [1:0] r = RESP_OKAY, input int t = 0);
		int n;
		n = 0;
		@(posedge MCLK);
		rq.push_back({r, 16'h0000, e});
		tq.push_back(34'(t));
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			n++;
			if (n > 50) give_up();
		end while (!ARREADY);
		ARVALID <= 1'b0;
		do begin
			@(posedge MCLK);
			n++;
			if (n > 100) give_up();
		end while (!RVALID);
		RREADY <= 1'b0;
	endtask
	// results are judged where they appear, against the oldest note
	always @(posedge MCLK) begin
		if (RVALID && RREADY) begin
			seen = {RRESP, RDATA};
			want = rq.pop_front();
			tol = tq.pop_front();
			// free prescaler phase leaves a window, not one value
			if (seen >= want && seen <= want + tol) want = seen;
			check(seen, want);
		end
		if (BVALID && BREADY) check(34'(BRESP), 34'(bq.pop_front()));
		if (ADC_TRIGGER) adc_seen <= 1'b1;
	end
	initial begin
		repeat (10) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		rd(OFF_COUNT, 16'h0000);
		rd(OFF_CONST_A, 16'hFFFF);
		rd(OFF_CONST_B, 16'hFFFF);
		rd(OFF_CTRL, 16'h0000);
		rd(8'h40, 16'h0000, RESP_DECERR);
		axw(8'h40, 16'h1234, 4'h3, RESP_DECERR);
		rd(OFF_CTRL, 16'h0000);
		repeat (3) begin
			seed = xs(seed);
			axw(OFF_COUNT, seed[15:0], 4'h3);
			rd(OFF_COUNT, seed[15:0]);
		end
		// wrap of channel 1 from FF
		axw(OFF_CONST_A, 16'h0380, 4'h3);
		axw(OFF_CONST_B, 16'h8080, 4'h3);
		rd(OFF_CONST_A, 16'h0380);
		axw(OFF_COUNT, 16'h00FF, 4'h3);
		axw(OFF_STATUS, 16'hE0E0, 4'h3);
		axw(OFF_CTRL, 16'h0025, 4'h1);
		pins.pulse(1, 1, 2);
		check(34'(WRAP_IRQ), 34'h2);
		rd(OFF_COUNT, 16'h0000);
		rd(OFF_STATUS, 16'h0020);
		axw(OFF_CTRL, 16'h0005, 4'h1);
		check(34'(WRAP_IRQ), 34'h0);
		axw(OFF_STATUS, 16'h0020, 4'h1);
		rd(OFF_STATUS, 16'h0000);
		// match A on channel 0 clears the count and drives the pin
		axw(OFF_STATUS, 16'h1200, 4'h2);
		axw(OFF_CTRL, 16'h4D00, 4'h2);
		pins.pulse(0, 2, 2);
		check(34'(MATCH_A_IRQ), 34'h0);
		pins.pulse(0, 1, 2);
		check(34'(MATCH_A_IRQ), 34'h1);
		check(34'(TIMER_OUT_PIN), 34'h1);
		check(34'(adc_seen), 34'h1);
		rd(OFF_COUNT, 16'h0000);
		axw(OFF_CTRL, 16'h0D00, 4'h2);
		check(34'(MATCH_A_IRQ), 34'h0);
		axw(OFF_STATUS, 16'h4000, 4'h2);
		// channel 1: falling edges, pin clear by edge then by level
		axw(OFF_COUNT, 16'h0010, 4'h1);
		axw(OFF_CTRL, 16'h001E, 4'h1);
		pins.pulse(1, 1, 2);
		rd(OFF_COUNT, 16'h0011);
		pins.set_reset(1, 1'b1);
		pins.set_reset(1, 1'b0);
		rd(OFF_COUNT, 16'h0000);
		axw(OFF_CLKCTL, 16'h0008, 4'h1);
		pins.set_reset(1, 1'b1);
		pins.pulse(1, 2, 2);
		rd(OFF_COUNT, 16'h0000);
		pins.set_reset(1, 1'b0);
		pins.pulse(1, 1, 2);
		rd(OFF_COUNT, 16'h0001);
		// cascade both ways
		axw(OFF_CTRL, 16'h0405, 4'h3);
		axw(OFF_COUNT, 16'h00FF, 4'h3);
		pins.pulse(1, 1, 2);
		rd(OFF_COUNT, 16'h0100);
		axw(OFF_CONST_B, 16'h0280, 4'h2);
		axw(OFF_CTRL, 16'h8504, 4'h3);
		axw(OFF_COUNT, 16'h0000, 4'h3);
		pins.pulse(0, 3, 1);
		check(34'(MATCH_B_IRQ), 34'h1);
		rd(OFF_COUNT, 16'h0301);
		// prescaler taps, rising edges, counted over a fixed span
		axw(OFF_CTRL, 16'h0000, 4'h3);
		foreach (divs[i]) begin
			axw(OFF_CLKCTL, {6'h00, 2'(i % 2), 8'h00}, 4'h2);
			axw(OFF_COUNT, 16'h0000, 4'h3);
			axw(OFF_CTRL, {5'h00, 3'(i / 2 + 1), 8'h00}, 4'h2);
			repeat (80) @(posedge MCLK);
			axw(OFF_CTRL, 16'h0000, 4'h2);
			rd(OFF_COUNT, {8'(80 / divs[i] - 1), 8'h00}, RESP_OKAY,
				256 * (8 / divs[i] + 3));
		end
		// channel 1: clear on match B, pin toggled, then driven low
		axw(OFF_CONST_B, 16'h0002, 4'h1);
		axw(OFF_COUNT, 16'h0000, 4'h3);
		axw(OFF_STATUS, 16'h000C, 4'h1);
		axw(OFF_CTRL, 16'h0015, 4'h1);
		pins.pulse(1, 2, 2);
		check(34'(TIMER_OUT_PIN), 34'h3);
		rd(OFF_COUNT, 16'h0000);
		axw(OFF_STATUS, 16'h0004, 4'h1);
		pins.pulse(1, 2, 2);
		check(34'(TIMER_OUT_PIN), 34'h1);
		// slow tap on its falling edge, a bit over one period
		axw(OFF_CLKCTL, 16'h0300, 4'h2);
		axw(OFF_COUNT, 16'h0000, 4'h2);
		axw(OFF_CTRL, 16'h0300, 4'h2);
		repeat (1100) @(posedge MCLK);
		axw(OFF_CTRL, 16'h0000, 4'h2);
		rd(OFF_COUNT, 16'h0100, RESP_OKAY, 256);
		stop_test();
	end
endmodule

// file: verilog/dual_channel_8bit_timer.sv
// two cascadable 8-bit compare-match timer channels, AXI4-Lite slave
// assumes pins synchronous to MCLK; channel 0 sits in byte lane 1
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module dual_channel_8bit_timer (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [dual_timer_pkg::AXI_ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [dual_timer_pkg::AXI_ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic [1:0] EXT_CLOCK_PIN,
	input wire logic [1:0] EXT_RESET_PIN,
	output logic [1:0] TIMER_OUT_PIN,
	output logic [1:0] MATCH_A_IRQ,
	output logic [1:0] MATCH_B_IRQ,
	output logic [1:0] WRAP_IRQ,
	output logic ADC_TRIGGER
);
	import dual_timer_pkg::*;

	logic aw_held;
	logic w_held;
	logic [AXI_ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic do_write;
	logic [31:0] rd_word;
	logic rd_known;
	logic [7:0] count [2];
	logic [7:0] const_a [2];
	logic [7:0] const_b [2];
	logic [7:0] ctrl [2];
	logic [7:0] clkctl [2];
	logic [7:0] status [2];
	logic [7:0] wbyte [2];
	logic [1:0] wr_count;
	logic [1:0] wr_ctrl;
	logic [1:0] wr_status;
	logic [1:0] sup_a;
	logic [1:0] sup_b;
	logic [1:0] match_a_q;
	logic [1:0] match_b_q;
	logic [1:0] match_a_ev;
	logic [1:0] match_b_ev;
	logic [1:0] step;
	logic [1:0] clear;
	logic [1:0] wrap_ev;
	logic [1:0] ext_clk_q;
	logic [1:0] ext_rst_q;
	logic [PRESCALE_W-1:0] prescale;
	logic [PRESCALE_W-1:0] prescale_q;

	function automatic logic known_reg(input logic [AXI_ADDR_W-1:0] a);
		return a == OFF_COUNT || a == OFF_CONST_A || a == OFF_CONST_B ||
			a == OFF_CTRL || a == OFF_CLKCTL || a == OFF_STATUS;
	endfunction

	function automatic logic wr_hit(input logic [AXI_ADDR_W-1:0] a,
			input logic [AXI_ADDR_W-1:0] off, input logic go);
		return go && a == off;
	endfunction

	// one count edge for a channel, chosen by its clock selects
	function automatic logic clk_step(input logic [2:0] cks,
			input logic prescale_tap_sel_1, input logic prescale_tap_sel_0,
			input logic [PRESCALE_W-1:0] pre,
			input logic [PRESCALE_W-1:0] pre_q,
			input logic xrise, input logic xfall, input logic casc);
		logic [3:0] tap;
		logic rise;
		logic fall;
		logic hit;
		tap = TAP_DIV8;
		case (clk_sel_t'(cks))
			CK_FAST: tap = prescale_tap_sel_0 ? TAP_DIV2 : TAP_DIV8;
			CK_MID: tap = prescale_tap_sel_0 ? TAP_DIV32 : TAP_DIV64;
			CK_SLOW: tap = prescale_tap_sel_0 ? TAP_DIV1024 : TAP_DIV8192;
			default: tap = TAP_DIV8;
		endcase
		rise = pre[tap] & ~pre_q[tap];
		fall = ~pre[tap] & pre_q[tap];
		case (clk_sel_t'(cks))
			CK_OFF: hit = 1'b0;
			CK_FAST, CK_MID, CK_SLOW: hit = prescale_tap_sel_1 ? fall : rise;
			CK_CASCADE: hit = casc;
			CK_EXT_RISE: hit = xrise;
			CK_EXT_FALL: hit = xfall;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	function automatic logic out_next(input logic cur, input logic [1:0] act);
		logic v;
		case (out_act_t'(act))
			OUT_LOW: v = 1'b0;
			OUT_HIGH: v = 1'b1;
			OUT_TOGGLE: v = ~cur;
			default: v = cur;
		endcase
		return v;
	endfunction

	// bus slave: address and data taken in either order
	assign AWREADY = !aw_held && !BVALID;
	assign WREADY = !w_held && !BVALID;
	assign ARREADY = !RVALID;
	assign do_write = aw_held && w_held && !BVALID;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			aw_held <= 1'b0;
			wr_addr <= '0;
		end else if (AWVALID && AWREADY) begin
			aw_held <= 1'b1;
			wr_addr <= AWADDR;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			w_held <= 1'b0;
			wr_data <= '0;
			wr_strb <= '0;
		end else if (WVALID && WREADY) begin
			w_held <= 1'b1;
			wr_data <= WDATA;
			wr_strb <= WSTRB;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			BVALID <= 1'b0;
			BRESP <= RESP_OKAY;
		end else if (do_write) begin
			BVALID <= 1'b1;
			BRESP <= known_reg(wr_addr) ? RESP_OKAY : RESP_DECERR;
		end else if (BREADY) begin
			BVALID <= 1'b0;
		end
	end
	// channel 0 in the high byte so a 16-bit read sees one cascaded value
	always_comb begin
		rd_known = known_reg(ARADDR);
		rd_word = '0;
		case (ARADDR)
			OFF_COUNT: rd_word[15:0] = {count[0], count[1]};
			OFF_CONST_A: rd_word[15:0] = {const_a[0], const_a[1]};
			OFF_CONST_B: rd_word[15:0] = {const_b[0], const_b[1]};
			OFF_CTRL: rd_word[15:0] = {ctrl[0], ctrl[1]};
			OFF_CLKCTL: rd_word[15:0] = {clkctl[0], clkctl[1]};
			OFF_STATUS: rd_word[15:0] = {status[0], status[1]};
			default: rd_word = '0;
		endcase
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			RVALID <= 1'b0;
			RDATA <= '0;
			RRESP <= RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RDATA <= rd_word;
			RRESP <= rd_known ? RESP_OKAY : RESP_DECERR;
		end else if (RREADY) begin
			RVALID <= 1'b0;
		end
	end
	// lane decode and the counting chain; channel 1 settles before 0
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			wbyte[i] = wr_data[(1 - i) * 8 +: 8];
			wr_count[i] = wr_hit(wr_addr, OFF_COUNT, do_write)
				&& wr_strb[1 - i];
			wr_ctrl[i] = wr_hit(wr_addr, OFF_CTRL, do_write) && wr_strb[1 - i];
			wr_status[i] = wr_hit(wr_addr, OFF_STATUS, do_write)
				&& wr_strb[1 - i];
			sup_a[i] = wr_hit(wr_addr, OFF_CONST_A, do_write)
				&& wr_strb[1 - i];
			sup_b[i] = wr_hit(wr_addr, OFF_CONST_B, do_write)
				&& wr_strb[1 - i];
			match_a_ev[i] = count[i] == const_a[i] && !sup_a[i]
				&& !match_a_q[i];
			match_b_ev[i] = count[i] == const_b[i] && !sup_b[i]
				&& !match_b_q[i];
			case (clr_sel_t'(ctrl[i][CTRL_CLR_LSB +: 2]))
				CLR_MATCH_A: clear[i] = match_a_ev[i];
				CLR_MATCH_B: clear[i] = match_b_ev[i];
				CLR_EXT: clear[i] = clkctl[i][CLK_RESET_INPUT_SELECT] ? EXT_RESET_PIN[i]
					: EXT_RESET_PIN[i] & ~ext_rst_q[i];
				default: clear[i] = 1'b0;
			endcase
		end
		step = '0;
		wrap_ev = '0;
		for (int k = 1; k >= 0; k--) begin
			step[k] = clk_step(ctrl[k][CTRL_CKS_LSB +: 3],
				clkctl[k][CLK_PRESCALE_TAP_SEL_1], clkctl[k][CLK_PRESCALE_TAP_SEL_0], prescale,
				prescale_q, EXT_CLOCK_PIN[k] & ~ext_clk_q[k],
				~EXT_CLOCK_PIN[k] & ext_clk_q[k],
				k == 0 ? wrap_ev[1] : match_a_ev[0]);
			wrap_ev[k] = step[k] && count[k] == 8'hFF && !clear[k]
				&& !wr_count[k];
		end
	end

	// taps of a free-running divider; bit n divides by 2^(n+1)
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			prescale <= '0;
			prescale_q <= '0;
		end else begin
			prescale <= prescale + 1'b1;
			prescale_q <= prescale;
		end
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ext_clk_q <= '0;
			ext_rst_q <= '0;
			match_a_q <= '0;
			match_b_q <= '0;
		end else begin
			ext_clk_q <= EXT_CLOCK_PIN;
			ext_rst_q <= EXT_RESET_PIN;
			for (int i = 0; i < 2; i++) begin
				match_a_q[i] <= count[i] == const_a[i] && !sup_a[i];
				match_b_q[i] <= count[i] == const_b[i] && !sup_b[i];
			end
		end
	end

	// software write wins over clear, clear wins over a count edge
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			count[0] <= RST_COUNT;
			count[1] <= RST_COUNT;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_count[i]) begin
					count[i] <= wbyte[i];
				end else if (clear[i]) begin
					count[i] <= RST_COUNT;
				end else if (step[i]) begin
					count[i] <= count[i] + 8'h01;
				end
			end
		end
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < 2; i++) begin
				const_a[i] <= RST_CONST;
				const_b[i] <= RST_CONST;
				ctrl[i] <= RST_CTRL;
				clkctl[i] <= RST_CLKCTL;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (sup_a[i]) begin
					const_a[i] <= wbyte[i];
				end
				if (sup_b[i]) begin
					const_b[i] <= wbyte[i];
				end
				if (wr_ctrl[i]) begin
					ctrl[i] <= wbyte[i];
				end
				if (wr_hit(wr_addr, OFF_CLKCTL, do_write) && wr_strb[1 - i]) begin
					clkctl[i] <= wbyte[i] & CLKCTL_MASK;
				end
			end
		end
	end

	// flags clear by writing one; an event in the same cycle still sets
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			status[0] <= RST_STATUS;
			status[1] <= RST_STATUS;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_status[i]) begin
					status[i][STAT_ADC_EN:0] <= wbyte[i][STAT_ADC_EN:0];
				end
				status[i][STAT_MB_FLAG] <= match_b_ev[i] |
					(status[i][STAT_MB_FLAG] &
					~(wr_status[i] & wbyte[i][STAT_MB_FLAG]));
				status[i][STAT_MA_FLAG] <= match_a_ev[i] |
					(status[i][STAT_MA_FLAG] &
					~(wr_status[i] & wbyte[i][STAT_MA_FLAG]));
				status[i][STAT_WRAP_FLAG] <= wrap_ev[i] |
					(status[i][STAT_WRAP_FLAG] &
					~(wr_status[i] & wbyte[i][STAT_WRAP_FLAG]));
			end
		end
	end

	// match B is applied after match A, so B decides a tie
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			TIMER_OUT_PIN <= '0;
			ADC_TRIGGER <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				TIMER_OUT_PIN[i] <= out_next(out_next(TIMER_OUT_PIN[i],
					match_a_ev[i] ? status[i][STAT_OSA_LSB +: 2] : 2'b00),
					match_b_ev[i] ? status[i][STAT_OSB_LSB +: 2] : 2'b00);
			end
			ADC_TRIGGER <= match_a_ev[0] & status[0][STAT_ADC_EN];
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			MATCH_B_IRQ[i] = status[i][STAT_MB_FLAG] & ctrl[i][CTRL_MB_IE];
			MATCH_A_IRQ[i] = status[i][STAT_MA_FLAG] & ctrl[i][CTRL_MA_IE];
			WRAP_IRQ[i] = status[i][STAT_WRAP_FLAG] & ctrl[i][CTRL_WRAP_IE];
		end
	end

	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);

	count_write_a: assert property (wr_count[1] |=> count[1] == $past(wbyte[1]))
		else $error("counter did not take written value");
	wrap_flag_a: assert property (wrap_ev[1] |=> count[1] == 8'h00 && status[1][STAT_WRAP_FLAG])
		else $error("wrap did not zero counter and set flag");
	match_a_flag_a: assert property (match_a_ev[0] |=> status[0][STAT_MA_FLAG])
		else $error("match A flag not set");
	suppress_a_a: assert property (sup_a[0] && !status[0][STAT_MA_FLAG] |=> !status[0][STAT_MA_FLAG])
		else $error("match A flag set during constant write");
	suppress_b_a: assert property (sup_b[0] && !status[0][STAT_MB_FLAG] |=> !status[0][STAT_MB_FLAG])
		else $error("match B flag set during constant write");
	match_b_flag_a: assert property (match_b_ev[0] |=> status[0][STAT_MB_FLAG])
		else $error("match B flag not set");
	irq_b_gate_a: assert property (match_b_ev[0] && ctrl[0][CTRL_MB_IE] && !wr_ctrl[0] |=> MATCH_B_IRQ[0])
		else $error("match B request missing");
	irq_a_block_a: assert property (!ctrl[1][CTRL_MA_IE] |-> !MATCH_A_IRQ[1])
		else $error("match A request not blocked");
	irq_wrap_hold_a: assert property (WRAP_IRQ[1] && !wr_status[1] && !wr_ctrl[1] |=> WRAP_IRQ[1])
		else $error("wrap request dropped without clear");
	clear_prio_a: assert property (clear[1] && step[1] && !wr_count[1] |=> count[1] == 8'h00)
		else $error("count edge beat clear");
	cascade_a: assert property (ctrl[1][2:0] == 3'b100 && match_a_ev[0] && !clear[1] && !wr_count[1]
		|=> count[1] == $past(count[1]) + 8'h01)
		else $error("channel 1 missed channel 0 match A");
	stop_hold_a: assert property (ctrl[0][2:0] == 3'b000 && !clear[0] && !wr_count[0] |=> $stable(count[0]))
		else $error("stopped counter moved");

	cascade_wrap_c: cover property (ctrl[0][2:0] == 3'b100 && wrap_ev[1] ##1 count[0] != 8'h00);
	clear_on_a_c: cover property (ctrl[0][4:3] == 2'b01 && match_a_ev[0] ##1 count[0] == 8'h00);
	ext_reset_c: cover property (ctrl[1][4:3] == 2'b11 && clear[1]);
	adc_trig_c: cover property (ADC_TRIGGER);
endmodule

// file: verilog/dual_timer_pkg.sv
// constants, field layout and codes of the dual 8-bit timer
// assumes a 32-bit AXI4-Lite slave with byte addresses
package dual_timer_pkg;
	localparam int AXI_ADDR_W = 8;
	localparam logic [AXI_ADDR_W-1:0] OFF_COUNT = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] OFF_CONST_A = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] OFF_CONST_B = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] OFF_CTRL = 8'h0C;
	localparam logic [AXI_ADDR_W-1:0] OFF_CLKCTL = 8'h10;
	localparam logic [AXI_ADDR_W-1:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_CONST = 8'hFF;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_CLKCTL = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] CLKCTL_MASK = 8'h0B;
	localparam int CTRL_MB_IE = 7;
	localparam int CTRL_MA_IE = 6;
	localparam int CTRL_WRAP_IE = 5;
	localparam int CTRL_CLR_LSB = 3;
	localparam int CTRL_CKS_LSB = 0;
	localparam int CLK_RESET_INPUT_SELECT = 3;
	localparam int CLK_PRESCALE_TAP_SEL_1 = 1;
	localparam int CLK_PRESCALE_TAP_SEL_0 = 0;
	localparam int STAT_MB_FLAG = 7;
	localparam int STAT_MA_FLAG = 6;
	localparam int STAT_WRAP_FLAG = 5;
	localparam int STAT_ADC_EN = 4;
	localparam int STAT_OSB_LSB = 2;
	localparam int STAT_OSA_LSB = 0;
	localparam int PRESCALE_W = 13;
	localparam logic [3:0] TAP_DIV2 = 4'h0;
	localparam logic [3:0] TAP_DIV8 = 4'h2;
	localparam logic [3:0] TAP_DIV32 = 4'h4;
	localparam logic [3:0] TAP_DIV64 = 4'h5;
	localparam logic [3:0] TAP_DIV1024 = 4'h9;
	localparam logic [3:0] TAP_DIV8192 = 4'hC;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [2:0] {CK_OFF = 3'b000, CK_FAST = 3'b001,
		CK_MID = 3'b010, CK_SLOW = 3'b011, CK_CASCADE = 3'b100,
		CK_EXT_RISE = 3'b101, CK_EXT_FALL = 3'b110} clk_sel_t;
	typedef enum logic [1:0] {CLR_NONE = 2'b00, CLR_MATCH_A = 2'b01,
		CLR_MATCH_B = 2'b10, CLR_EXT = 2'b11} clr_sel_t;
	typedef enum logic [1:0] {OUT_KEEP = 2'b00, OUT_LOW = 2'b01,
		OUT_HIGH = 2'b10, OUT_TOGGLE = 2'b11} out_act_t;
endpackage
